// ---- logic/pdbt_consts.svh ----
// Purpose: named constants of the ddr bus transaction layer
// Assumes: word addressed array, 16-bit words, 8-bit bus
// Notes: field positions refer to the 48-bit command/address word
`ifndef PDBT_CONSTS_SVH
`define PDBT_CONSTS_SVH

`define PDBT_CA_W        48
`define PDBT_CA_RW       47
`define PDBT_CA_SPACE    46
`define PDBT_CA_BURST    45
`define PDBT_CA_ROW_HI   35
`define PDBT_CA_ROW_LO   16
`define PDBT_CA_COL_HI   2
`define PDBT_ADDR_W      23
`define PDBT_ROW_W       20
`define PDBT_LAT_W       4
`define PDBT_CNT_W       8
`define PDBT_WRAP_W      3
`define PDBT_NEG_ACT     2'h1
`define PDBT_NEG_LAST    2'h2
`define PDBT_NEG_SAT     2'h3
`define PDBT_CA_POS_LAST 8'h03
`define PDBT_CNT_ONE     8'h01
`define PDBT_BE_FULL     2'h3
`define PDBT_RD_DEPTH    3'h4

`endif

// ---- logic/pdbt_pkg.sv ----
// Purpose: shared types of the ddr bus transaction layer
// Assumes: constants come from pdbt_consts.svh
// Notes: latency doubling is shared by logic and checks
`include "pdbt_consts.svh"
package pdbt_pkg;

  typedef enum logic [1:0] {
    PDBT_IDLE = 2'b00,
    PDBT_CA   = 2'b01,
    PDBT_LAT  = 2'b10,
    PDBT_DATA = 2'b11
  } pdbt_state_t;

  // a zero count is treated as one clock; no encoding is assumed
  function automatic logic [`PDBT_CNT_W-1:0] pdbt_lat_target(
    input logic [`PDBT_LAT_W-1:0] lat,
    input logic                   extra);
    logic [`PDBT_CNT_W-1:0] base;
    base = (lat == '0) ? `PDBT_CNT_ONE : {4'h0, lat};
    pdbt_lat_target = extra ? (base << 1) : base;
  endfunction

endpackage

// ---- logic/pdbt_sync.sv ----
// Purpose: two flop synchroniser for levels and toggles
// Assumes: each bit is a level or a toggle, never a coherent word
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module pdbt_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule // pdbt_sync

// ---- logic/pdbt_burst_addr.sv ----
// Purpose: next word address of a burst
// Assumes: wrap span is a power of two words
// Notes: linear count rolls over at the top of the array
`timescale 1ns/1ps
`include "pdbt_consts.svh"
module pdbt_burst_addr import pdbt_pkg::*; (
  input  wire logic [`PDBT_ADDR_W-1:0] curAddr,
  input  wire logic [`PDBT_ADDR_W-1:0] startAddr,
  input  wire logic                    wrapped,
  input  wire logic                    hybrid,
  input  wire logic                    wrapDone,
  input  wire logic [`PDBT_WRAP_W-1:0] wrapLog2,
  output logic      [`PDBT_ADDR_W-1:0] nextAddr,
  output logic                         wrapDoneNxt
);

  wire [`PDBT_ADDR_W-1:0] span     = `PDBT_ADDR_W'(1) << wrapLog2;
  wire [`PDBT_ADDR_W-1:0] mask     = span - `PDBT_ADDR_W'(1);
  wire [`PDBT_ADDR_W-1:0] incAddr  = curAddr + `PDBT_ADDR_W'(1);
  wire [`PDBT_ADDR_W-1:0] wrapNext = (curAddr & ~mask) | (incAddr & mask);
  wire [`PDBT_ADDR_W-1:0] boundary = (startAddr & ~mask) + span;
  wire                    inWrap   = wrapped && !(hybrid && wrapDone);
  wire                    wrapEnd  = hybrid && (wrapNext == startAddr);

  // wrapped stays in its span; hybrid leaves at the next boundary
  assign nextAddr    = !inWrap ? incAddr :
                       wrapEnd ? boundary : wrapNext;
  assign wrapDoneNxt = wrapDone || (inWrap && wrapEnd);

endmodule // pdbt_burst_addr

// ---- logic/pdbt_bus.sv ----
// Purpose: device end of the ddr transaction bus, array side on clk
// Assumes: the array side answers reads well ahead of the bus
// Notes: frame logic runs on ck and is held in reset while csN is high; read pointer and request flops are not
`timescale 1ns/1ps
`include "pdbt_consts.svh"
// Summary of operation
// - top command bit one reads, zero writes
// - next bit picks array or register space
// - burst bit picks wrapped or linear burst
// - three words give row, column, word
// - row access opens after second word
// - latency doubles when strobe flagged high
// - strobe shows extra latency during command
// - read strobe toggles with every data byte
// - register words travel high byte first
// - write bytes taken rising then falling
// - transfer runs while clock toggles, cs low
// - wrapped stays in span, linear runs on
// - linear burst rolls over array end
// - hybrid wraps once then goes linear
// - strobe released after command on writes
// - write strobe high masks its byte
// - no latency signalling once write data flows
// - zero latency writes are full, strobe undriven
// - clock may stop while cs is high
// - register writes carry zero latency
module pdbt_bus import pdbt_pkg::*; (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    ck,
  input  wire logic                    csN,
  input  wire logic [7:0]              dqIn,
  output logic      [7:0]              dqOut,
  output logic                         dqOe,
  input  wire logic                    rwDataStrobeIn,
  output logic                         rwDataStrobeOut,
  output logic                         rwDataStrobeOe,
  input  wire logic [`PDBT_LAT_W-1:0]  latencyCount,
  input  wire logic [`PDBT_WRAP_W-1:0] wrapLog2,
  input  wire logic                    hybridWrap,
  input  wire logic                    refreshBusy,
  output logic                         memActivate,
  output logic      [`PDBT_ROW_W-1:0]  memRow,
  output logic                         memReq,
  output logic                         memWe,
  output logic                         memIsReg,
  output logic      [`PDBT_ADDR_W-1:0] memAddr,
  output logic      [15:0]             memWrData,
  output logic      [1:0]              memByteEn,
  input  wire logic [15:0]             memRdData,
  input  wire logic                    memRdValid
);

  localparam int CFG_W = `PDBT_LAT_W + `PDBT_WRAP_W + 2;

  // csN high ends the frame even when ck has already stopped
  wire linkRst_n = rst_n & ~csN;

  // ---------------- configuration into the ck domain
  logic [CFG_W-1:0]        cfgLink;
  logic [`PDBT_LAT_W-1:0]  latLink;
  logic [`PDBT_WRAP_W-1:0] wrapLink;
  logic                    hybridLink;
  logic                    extraLink;

  // static settings; software changes them only between frames
  pdbt_sync #(.WIDTH(CFG_W)) u_cfgSync (
    .clk   (ck),
    .rst_n (rst_n),
    .din   ({latencyCount, wrapLog2, hybridWrap, refreshBusy}),
    .dout  (cfgLink)
  );

  assign {latLink, wrapLink, hybridLink, extraLink} = cfgLink;

  // ---------------- rising edge side of the bus
  pdbt_state_t             state_r;
  pdbt_state_t             stateNxt;
  logic [`PDBT_CNT_W-1:0]  cnt_r;
  logic [`PDBT_CNT_W-1:0]  cntNxt;
  logic [7:0]              hiByte_r;
  logic                    hiMask_r;
  logic                    extraLat_r;
  logic [15:0]             outWord_r;
  logic [2:0]              rdPtr_r;
  logic [2:0]              wrPtrLink;
  logic [15:0]             rdBuf [4];

  // ---------------- falling edge side of the bus
  logic [1:0]              negCnt_r;
  logic [31:0]             caSh_r;
  logic                    isRead_r;
  logic                    isReg_r;
  logic                    linear_r;
  logic [`PDBT_ADDR_W-1:0] start_r;
  logic [`PDBT_ADDR_W-1:0] addr_r;
  logic                    wrapDone_r;
  logic [2:0]              rdIss_r;

  wire [`PDBT_CA_W-1:0] caFull   = {caSh_r, hiByte_r, dqIn};
  wire                  caDecode = (negCnt_r == `PDBT_NEG_LAST);
  wire                  caAct    = (negCnt_r == `PDBT_NEG_ACT);
  wire                  inData   = (state_r == PDBT_DATA);
  wire                  readData = inData && isRead_r;
  wire                  regWrite = isReg_r && !isRead_r;

  wire [`PDBT_ADDR_W-1:0] caStart = {caFull[`PDBT_CA_ROW_HI:`PDBT_CA_ROW_LO],
                                     caFull[`PDBT_CA_COL_HI:0]};
  wire [`PDBT_ROW_W-1:0]  caRow   = {caSh_r[`PDBT_CA_ROW_HI-32:0],
                                     hiByte_r, dqIn};

  wire                    curRead   = caDecode ? caFull[`PDBT_CA_RW] : isRead_r;
  wire                    curLinear = caDecode ? caFull[`PDBT_CA_BURST]
                                               : linear_r;
  wire [`PDBT_ADDR_W-1:0] curStart  = caDecode ? caStart : start_r;
  wire [`PDBT_ADDR_W-1:0] curAddr   = caDecode ? caStart : addr_r;
  wire                    curDone   = caDecode ? 1'b0 : wrapDone_r;
  wire [`PDBT_ADDR_W-1:0] nextAddr;
  wire                    wrapDoneNxt;

  // reads run up to four words ahead: the way back costs three ck rises
  wire rdRoom   = (rdIss_r - rdPtr_r) < `PDBT_RD_DEPTH;
  wire rdAhead  = isRead_r && (state_r == PDBT_LAT || inData) && rdRoom;
  wire issueReq = (caDecode && curRead) || rdAhead || (inData && !isRead_r);
  wire [1:0] reqBeNow = regWrite ? `PDBT_BE_FULL
                                 : ~{hiMask_r, rwDataStrobeIn};

  wire [`PDBT_CNT_W-1:0] latTarget = pdbt_lat_target(latLink, extraLat_r);

  pdbt_burst_addr u_burstAddr (
    .curAddr     (curAddr),
    .startAddr   (curStart),
    .wrapped     (!curLinear),
    .hybrid      (hybridLink),
    .wrapDone    (curDone),
    .wrapLog2    (wrapLink),
    .nextAddr    (nextAddr),
    .wrapDoneNxt (wrapDoneNxt)
  );

  always_comb begin
    stateNxt = state_r;
    cntNxt   = cnt_r;
    case (state_r)
      PDBT_IDLE: begin
        stateNxt = PDBT_CA;
        cntNxt   = `PDBT_CNT_ONE;
      end
      PDBT_CA: begin
        if (cnt_r == `PDBT_CA_POS_LAST) begin
          stateNxt = regWrite ? PDBT_DATA : PDBT_LAT;
          cntNxt   = `PDBT_CNT_ONE;
        end else begin
          cntNxt = cnt_r + `PDBT_CNT_ONE;
        end
      end
      PDBT_LAT: begin
        if (cnt_r >= latTarget) begin
          stateNxt = PDBT_DATA;
        end else begin
          cntNxt = cnt_r + `PDBT_CNT_ONE;
        end
      end
      PDBT_DATA: begin
        stateNxt = PDBT_DATA;
      end
      default: begin
        stateNxt = PDBT_IDLE;
      end
    endcase
  end

  wire [2:0] wrPtrBin = {wrPtrLink[2], ^wrPtrLink[2:1], ^wrPtrLink};
  wire       rdWin    = isRead_r && (stateNxt == PDBT_DATA);
  wire       loadRd   = rdWin && (wrPtrBin != rdPtr_r);

  always_ff @(posedge ck or negedge linkRst_n) begin
    if (!linkRst_n) begin
      state_r    <= PDBT_IDLE;
      cnt_r      <= '0;
      hiByte_r   <= '0;
      hiMask_r   <= 1'b0;
      extraLat_r <= 1'b0;
    end else begin
      state_r  <= stateNxt;
      cnt_r    <= cntNxt;
      hiByte_r <= dqIn;
      hiMask_r <= rwDataStrobeIn;
      if (state_r == PDBT_IDLE) begin
        extraLat_r <= extraLink;
      end
    end
  end

  // pointer survives csN; words left from the last frame drop during command
  always_ff @(posedge ck or negedge rst_n) begin
    if (!rst_n) begin
      outWord_r <= '0;
      rdPtr_r   <= '0;
    end else if (state_r == PDBT_CA && !csN) begin
      rdPtr_r <= wrPtrBin;
    end else if (loadRd) begin
      outWord_r <= rdBuf[rdPtr_r[1:0]];
      rdPtr_r   <= rdPtr_r + 3'h1;
    end
  end

  always_ff @(negedge ck or negedge linkRst_n) begin
    if (!linkRst_n) begin
      negCnt_r   <= '0;
      caSh_r     <= '0;
      isRead_r   <= 1'b0;
      isReg_r    <= 1'b0;
      linear_r   <= 1'b0;
      start_r    <= '0;
      addr_r     <= '0;
      wrapDone_r <= 1'b0;
    end else begin
      if (negCnt_r != `PDBT_NEG_SAT) begin
        negCnt_r <= negCnt_r + 2'h1;
      end
      caSh_r <= caFull[31:0];
      if (caDecode) begin
        isRead_r <= caFull[`PDBT_CA_RW];
        isReg_r  <= caFull[`PDBT_CA_SPACE];
        linear_r <= caFull[`PDBT_CA_BURST];
        start_r  <= caStart;
        addr_r   <= caStart;
      end
      if (issueReq) begin
        addr_r     <= nextAddr;
        wrapDone_r <= wrapDoneNxt;
      end
    end
  end

  // ---------------- requests toward the array side
  logic                    reqTgl_r;
  logic                    actTgl_r;
  logic                    reqWe_r;
  logic                    reqReg_r;
  logic [`PDBT_ADDR_W-1:0] reqAddr_r;
  logic [15:0]             reqData_r;
  logic [1:0]              reqBe_r;
  logic [`PDBT_ROW_W-1:0]  actRow_r;

  always_ff @(negedge ck or negedge rst_n) begin
    if (!rst_n) begin
      reqTgl_r  <= 1'b0;
      actTgl_r  <= 1'b0;
      reqWe_r   <= 1'b0;
      reqReg_r  <= 1'b0;
      reqAddr_r <= '0;
      reqData_r <= '0;
      reqBe_r   <= '0;
      actRow_r  <= '0;
      rdIss_r   <= '0;
    end else begin
      if (state_r == PDBT_CA && !caDecode) begin
        rdIss_r <= rdPtr_r;
      end else if (issueReq && !csN && curRead) begin
        rdIss_r <= rdIss_r + 3'h1;
      end
      if (caAct && !csN) begin
        actTgl_r <= ~actTgl_r;
        actRow_r <= caRow;
      end
      if (issueReq && !csN) begin
        reqTgl_r  <= ~reqTgl_r;
        reqWe_r   <= !curRead;
        reqReg_r  <= caDecode ? caFull[`PDBT_CA_SPACE] : isReg_r;
        reqAddr_r <= curAddr;
        reqData_r <= {hiByte_r, dqIn};
        reqBe_r   <= reqBeNow;
      end
    end
  end

  // ---------------- pins
  assign dqOe           = readData && !csN;
  assign dqOut          = ck ? outWord_r[15:8] : outWord_r[7:0];
  // after the command words the strobe is the master's on writes
  assign rwDataStrobeOe = !csN && (state_r == PDBT_IDLE ||
                                   state_r == PDBT_CA || readData);
  assign rwDataStrobeOut = readData ? ck :
                           (state_r == PDBT_IDLE) ? extraLink
                                                  : extraLat_r;

  // ---------------- array side on clk
  logic [1:0] tglSync;
  logic       reqSeen_r;
  logic       actSeen_r;
  logic [2:0] wrPtr_r;
  logic [2:0] wrGray_r;

  wire  [2:0] wrPtrInc = wrPtr_r + 3'h1;

  pdbt_sync #(.WIDTH(2)) u_tglSync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({reqTgl_r, actTgl_r}),
    .dout  (tglSync)
  );

  // only the gray write pointer crosses; words wait in rdBuf
  pdbt_sync #(.WIDTH(3)) u_ackSync (
    .clk   (ck),
    .rst_n (rst_n),
    .din   (wrGray_r),
    .dout  (wrPtrLink)
  );

  always_ff @(posedge clk) begin
    if (memRdValid) begin
      rdBuf[wrPtr_r[1:0]] <= memRdData;
    end
  end

  wire reqEdge = tglSync[1] != reqSeen_r;
  wire actEdge = tglSync[0] != actSeen_r;

  // request fields are held until the next toggle, two clk earlier
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqSeen_r   <= 1'b0;
      actSeen_r   <= 1'b0;
      memReq      <= 1'b0;
      memActivate <= 1'b0;
      memWe       <= 1'b0;
      memIsReg    <= 1'b0;
      memAddr     <= '0;
      memWrData   <= '0;
      memByteEn   <= '0;
      memRow      <= '0;
      wrPtr_r     <= '0;
      wrGray_r    <= '0;
    end else begin
      reqSeen_r   <= tglSync[1];
      actSeen_r   <= tglSync[0];
      memReq      <= reqEdge;
      memActivate <= actEdge;
      if (reqEdge) begin
        memWe     <= reqWe_r;
        memIsReg  <= reqReg_r;
        memAddr   <= reqAddr_r;
        memWrData <= reqData_r;
        memByteEn <= reqBe_r;
      end
      if (actEdge) begin
        memRow <= actRow_r;
      end
      if (memRdValid) begin
        wrPtr_r  <= wrPtrInc;
        wrGray_r <= wrPtrInc ^ (wrPtrInc >> 1);
      end
    end
  end

  // ---------------- checks
  chk_ca_three_clocks: assert property (
    @(posedge ck) disable iff (csN)
    (state_r == PDBT_IDLE) |=> (state_r == PDBT_CA) [*3])
    else $error("command phase not three clocks");

  chk_strobe_latency: assert property (
    @(posedge ck) disable iff (csN)
    (state_r == PDBT_CA) |-> (rwDataStrobeOe &&
                              rwDataStrobeOut == extraLat_r))
    else $error("strobe not flagging latency");

  chk_lat_length: assert property (
    @(posedge ck) disable iff (csN)
    (state_r == PDBT_LAT && cnt_r < latTarget) |=> (state_r == PDBT_LAT))
    else $error("latency cut short");

  chk_lat_end: assert property (
    @(posedge ck) disable iff (csN)
    (state_r == PDBT_LAT && cnt_r == latTarget) |=> (state_r == PDBT_DATA))
    else $error("latency overrun");

  chk_zero_lat_write: assert property (
    @(posedge ck) disable iff (csN)
    (state_r == PDBT_CA && cnt_r == `PDBT_CA_POS_LAST && regWrite)
    |=> (state_r == PDBT_DATA && !rwDataStrobeOe))
    else $error("register write not zero latency");

  chk_strobe_release: assert property (
    @(posedge ck) disable iff (csN)
    (state_r == PDBT_LAT && !isRead_r) |-> !rwDataStrobeOe)
    else $error("strobe held into write latency");

  chk_write_quiet: assert property (
    @(posedge ck) disable iff (csN)
    (inData && !isRead_r) |-> (!rwDataStrobeOe && !dqOe))
    else $error("device drove bus during write data");

  chk_read_drive: assert property (
    @(negedge ck) disable iff (csN)
    readData |-> (dqOe && rwDataStrobeOe && rwDataStrobeOut))
    else $error("read data not driven with strobe");

  chk_full_word: assert property (
    @(negedge ck) disable iff (csN)
    (inData && regWrite) |-> (reqBeNow == `PDBT_BE_FULL))
    else $error("zero latency write masked");

  chk_wrap_window: assert property (
    @(negedge ck) disable iff (csN)
    (inData && !linear_r && !hybridLink)
    |-> (((addr_r ^ start_r) >> wrapLink) == '0))
    else $error("wrapped burst left its span");

endmodule // pdbt_bus

// ---- sim/pdbt_host_model.sv ----
// Purpose: bus master model driving ck, csN, dq and the strobe
// Assumes: ck idles low while csN is high
// Notes: data phase runs slow so each word request reaches clk in time
`timescale 1ns/1ps
module pdbt_host_model (
  output logic            ck,
  output logic            csN,
  output logic [7:0]      hDq,
  output logic            hDqOe,
  output logic            hStrb,
  output logic            hStrbOe,
  input  wire logic [7:0] dqLine,
  input  wire logic       strbLine,
  input  wire logic       dqOe,
  input  wire logic       strbOe
);
  logic [15:0] wd [16];
  logic [1:0]  wm [16];
  logic [15:0] rdW [16];
  logic        strbCa;
  int          firstOe;
  int          nBad;

  initial begin
    ck = 1'b0;
    csN = 1'b1;
    hDq = 8'h00;
    hDqOe = 1'b0;
    hStrb = 1'b0;
    hStrbOe = 1'b0;
  end

  // data is set a quarter before each edge: centre aligned
  task automatic tick(input real q);
    #q;
    ck = ~ck;
    #q;
  endtask

  task automatic idle(input int n);
    repeat (2 * n) tick(3.75); // ck may run while csN is high
  endtask

  task automatic xfer(input logic [47:0] ca, input int lat, input int nw,
                      input bit isRd);
    int i;
    firstOe = -1;
    nBad = 0;
    hStrb = 1'b0;
    hDqOe = 1'b1;
    csN = 1'b0; // ck is low here
    for (i = 0; i < 6; i++) begin
      hDq = ca[47-8*i -: 8]; // rise byte then fall byte
      tick(3.75);
      if (i == 0) strbCa = strbLine;
      nBad += int'(strbOe !== 1'b1);
    end
    hDqOe = !isRd;
    for (i = 0; i < lat + nw; i++) begin
      if (i >= lat && !isRd) begin
        hDq = wd[i-lat][15:8]; // high byte on rise
        hStrb = wm[i-lat][1]; // strobe high masks the byte
      end
      tick(75.0);
      if (dqOe === 1'b1 && firstOe < 0) firstOe = i;
      if (i >= lat && isRd) begin
        rdW[i-lat][15:8] = dqLine;
        nBad += int'(strbLine !== 1'b1);
      end
      if (lat > 0 && !isRd) hStrbOe = 1'b1; // low preamble
      if (i >= lat && !isRd) begin
        hDq = wd[i-lat][7:0];
        hStrb = wm[i-lat][0];
      end
      tick(75.0);
      if (i >= lat && isRd) begin
        rdW[i-lat][7:0] = dqLine;
        nBad += int'(strbLine !== 1'b0);
      end
      if (!isRd) nBad += int'(strbOe !== 1'b0 || dqOe !== 1'b0);
    end
    #3.75;
    csN = 1'b1; // may end at any word
    hDqOe = 1'b0;
    hStrbOe = 1'b0;
    #30;
  endtask
endmodule // pdbt_host_model

// ---- sim/tb_psram_ddr_bus_transactions.sv ----
// Purpose: self-checking bench of the bus transaction block
// Assumes: config is static while csN is low
// Notes: floating lines show a pattern that flips every clk
`timescale 1ns/1ps
module tb_psram_ddr_bus_transactions;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  latencyCount = 4'h1;
  logic [2:0]  wrapLog2 = 3'h2;
  logic        hybridWrap = 1'b0, refreshBusy = 1'b0, flt = 1'b0;
  logic        memRdValid = 1'b0;
  logic [15:0] memRdData = 16'h0000;
  logic        ck, csN, hDqOe, hStrb, hStrbOe, dqOe, strbOut, strbOe;
  logic [7:0]  hDq, dqOut;
  logic        memActivate, memReq, memWe, memIsReg;
  logic [19:0] memRow;
  logic [22:0] memAddr, sAddr;
  logic [15:0] memWrData;
  logic [1:0]  memByteEn;
  wire  [7:0]  dqLine = dqOe ? dqOut : hDqOe ? hDq : {8{flt}};
  wire         strbLine = strbOe ? strbOut : hStrbOe ? hStrb : flt;
  integer      seed = 32'hE267E830;
  int          n_mismatch = 0, checked = 0, cyc = 0, eNw = 0, eIdx = 0, i;
  bit          eRd, eReg, eLin;

  always #10 clk = ~clk;
  always @(posedge clk) flt <= ~flt;

  pdbt_host_model host (.ck(ck), .csN(csN), .hDq(hDq), .hDqOe(hDqOe),
    .hStrb(hStrb), .hStrbOe(hStrbOe), .dqLine(dqLine), .strbLine(strbLine),
    .dqOe(dqOe), .strbOe(strbOe));

  pdbt_bus dut (.clk(clk), .rst_n(rst_n), .ck(ck), .csN(csN), .dqIn(dqLine),
    .dqOut(dqOut), .dqOe(dqOe), .rwDataStrobeIn(strbLine),
    .rwDataStrobeOut(strbOut), .rwDataStrobeOe(strbOe),
    .latencyCount(latencyCount), .wrapLog2(wrapLog2),
    .hybridWrap(hybridWrap), .refreshBusy(refreshBusy),
    .memActivate(memActivate), .memRow(memRow), .memReq(memReq),
    .memWe(memWe), .memIsReg(memIsReg), .memAddr(memAddr),
    .memWrData(memWrData), .memByteEn(memByteEn), .memRdData(memRdData),
    .memRdValid(memRdValid));

  function automatic logic [22:0] expA(input int k);
    logic [22:0] s, b;
    s = 23'h000001 << wrapLog2;
    b = sAddr & ~(s - 23'h000001);
    if (eLin) expA = sAddr + 23'(k);
    else if (hybridWrap && k >= int'(s)) expA = b + 23'(k);
    else expA = b + ((sAddr + 23'(k)) & (s - 23'h000001));
  endfunction

  function automatic logic [15:0] dat(input logic [22:0] a);
    dat = {a[7:0], a[22:15]} ^ 16'h3C5A;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // array side answers a read one clk after its request
  always @(posedge clk) begin
    cyc <= cyc + 1;
    memRdValid <= (memReq === 1'b1) && (memWe === 1'b0);
    if (memActivate === 1'b1) check(memRow, sAddr[22:3]);
    if (memReq === 1'b1) begin
      if (eIdx < eNw) begin
        check({memWe, memIsReg, memAddr}, {~eRd, eReg, expA(eIdx)});
        if (!eRd) check({memWrData, memByteEn},
          {host.wd[eIdx], eReg ? 2'h3 : ~host.wm[eIdx]});
      end
      eIdx <= eIdx + 1;
      memRdData <= dat(memAddr);
    end
    if (cyc == 12000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic frame(input bit rd, input bit sp, input bit lin,
                       input logic [22:0] a, input int nw);
    int t, lat, k;
    @(posedge clk);
    // reads need three clocks of head start to cross back to ck
    latencyCount <= 4'(3 + {$random(seed)} % 4);
    wrapLog2 <= 3'(1 + {$random(seed)} % 3);
    hybridWrap <= 1'($random(seed));
    refreshBusy <= 1'($random(seed));
    repeat (6) @(posedge clk);
    host.idle(3); // config crosses only on ck edges
    t = int'(latencyCount);
    lat = (sp && !rd) ? 0 : (refreshBusy ? 2 * t : t);
    for (k = 0; k < 16; k++) begin
      host.wd[k] = 16'($random(seed));
      host.wm[k] = 2'($random(seed));
    end
    sAddr = a;
    eRd = rd;
    eReg = sp;
    eLin = lin;
    eNw = nw;
    eIdx = 0;
    host.xfer({rd, sp, lin, 9'h000, a[22:3], 13'h0000, a[2:0]}, lat, nw, rd);
    repeat (20) @(posedge clk);
    check(host.strbCa, refreshBusy);
    check(host.firstOe, rd ? lat : -1);
    check(host.nBad, 0);
    check(32'(eIdx >= nw), 32'h1);
    if (rd) for (k = 0; k < nw; k++) check(host.rdW[k], dat(expA(k)));
  endtask

  initial begin
    host.idle(2);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    host.idle(3);
    frame(1'b1, 1'b0, 1'b1, 23'h7FFFFE, 4); // read over array top
    frame(1'b0, 1'b0, 1'b1, 23'h7FFFFF, 3); // write rolls to zero
    frame(1'b0, 1'b1, 1'b1, 23'h000001, 1); // register write
    frame(1'b1, 1'b1, 1'b0, 23'h000800, 1); // register read
    for (i = 0; i < 12; i++) // wrapped, hybrid and linear
      frame(1'($random(seed)), 1'b0, 1'($random(seed)), 23'($random(seed)),
            2 + {$random(seed)} % 10); // short bursts
    end_of_test();
  end
endmodule // tb_psram_ddr_bus_transactions
